/* hdl/frequency_reference_param_bank.sv */
`timescale 1ns/100ps
module frequency_reference_param_bank (
    input  wire logic                    clock,
    input  wire logic                    reset,
    input  wire logic                    enable,
    input  wire logic                    running,
    input  wire logic                    autotune_done,
    input  wire logic [4:0]              card_fitted,
    input  wire logic [1:0]              ramp_group_select,
    input  wire logic                    reverse_command,
    input  wire logic [14:0][15:0]       source_level,
    input  freq_ref_pkg::request_type    request,
    output freq_ref_pkg::response_type   response,
    output freq_ref_pkg::reference_type  reference
);

    freq_ref_pkg::state_type s_q;
    freq_ref_pkg::state_type s_d;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] scale(input logic [15:0] level,
                                          input logic [15:0] basis);
        logic [31:0] product;
        product = level * basis;
        return product[31:16];
    endfunction : scale

    function automatic logic [15:0] pick(input logic [15:0] code,
                                         input logic [15:0] basis,
                                         input logic [15:0] keypad);
        logic [15:0] value;
        value = 16'h0000;
        if (code[3:0] == freq_ref_pkg::SRC_KEYPAD) begin
            value = keypad;
        end else if (code[3:0] != freq_ref_pkg::SRC_RESERVED) begin
            value = scale(source_level[code[3:0]], basis);
        end
        return value;
    endfunction : pick

    function automatic logic [15:0] larger(input logic [15:0] a,
                                           input logic [15:0] b);
        return (a > b) ? a : b;
    endfunction : larger

    // ****************************************
    // Write checks
    // ****************************************
    function automatic logic basic_ok(input logic [3:0]  idx,
                                      input logic [15:0] v,
                                      input freq_ref_pkg::state_type s);
        logic ok;
        logic [15:0] max_f;
        logic [15:0] upper;
        logic [15:0] lower;
        ok    = 1'b0;
        max_f = s.param[freq_ref_pkg::IDX_MAX_FREQ];
        upper = s.param[freq_ref_pkg::IDX_UPPER];
        lower = s.param[freq_ref_pkg::IDX_LOWER];
        case (idx)
            freq_ref_pkg::IDX_CONTROL: begin
                ok = v <= freq_ref_pkg::CODE_MAX_MODE;
            end
            freq_ref_pkg::IDX_RUN_SOURCE: begin
                ok = v <= freq_ref_pkg::CODE_MAX_RUN;
            end
            freq_ref_pkg::IDX_COMM: begin
                ok = (v == 16'h0000) || ((v <= freq_ref_pkg::CODE_MAX_COMM)
                     && card_fitted[v[2:0] - 3'h1]);
            end
            freq_ref_pkg::IDX_MAX_FREQ: begin
                ok = (v >= larger(upper, freq_ref_pkg::MAX_FREQ_FLOOR))
                     && (v <= freq_ref_pkg::FREQ_CEILING);
            end
            freq_ref_pkg::IDX_UPPER: begin
                ok = (v >= lower) && (v <= max_f);
            end
            freq_ref_pkg::IDX_LOWER: begin
                ok = v <= upper;
            end
            freq_ref_pkg::IDX_MAIN_SRC: begin
                ok = v <= freq_ref_pkg::CODE_MAX_MAIN;
            end
            freq_ref_pkg::IDX_AUX_SRC: begin
                ok = v <= freq_ref_pkg::CODE_MAX_AUX;
            end
            freq_ref_pkg::IDX_AUX_BASIS: begin
                ok = v <= freq_ref_pkg::CODE_MAX_BASIS;
            end
            freq_ref_pkg::IDX_COMBINE: begin
                ok = v <= freq_ref_pkg::CODE_MAX_COMB;
            end
            freq_ref_pkg::IDX_KEYPAD: begin
                ok = v <= max_f;
            end
            freq_ref_pkg::IDX_ACCEL, freq_ref_pkg::IDX_DECEL: begin
                ok = v <= freq_ref_pkg::RAMP_CEILING;
            end
            freq_ref_pkg::IDX_DIRECTION: begin
                ok = v <= freq_ref_pkg::CODE_MAX_DIR;
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        return ok;
    endfunction : basic_ok

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic        src;
        logic        allowed;
        logic        mapped;
        logic        writable;
        logic [15:0] current;
        logic [15:0] value;
        logic [15:0] max_f;
        logic [15:0] main_f;
        logic [15:0] basis;
        logic [15:0] aux_f;
        logic [16:0] sum;
        logic [15:0] combined;
        logic [15:0] clamped;
        logic [1:0]  dir;
        logic [2:0]  slot;
        src      = 1'b0;
        allowed  = 1'b0;
        mapped   = 1'b0;
        writable = 1'b0;
        current  = 16'h0000;
        value    = 16'h0000;
        sum      = 17'h00000;
        combined = 16'h0000;
        slot     = 3'h0;
        s_d      = s_q;
        s_d.response.done  = 1'b0;
        s_d.response.error = 1'b0;
        s_d.response.rdata = 16'h0000;

        // Reference path
        max_f  = s_q.param[freq_ref_pkg::IDX_MAX_FREQ];
        main_f = pick(s_q.param[freq_ref_pkg::IDX_MAIN_SRC], max_f,
                      s_q.param[freq_ref_pkg::IDX_KEYPAD]);
        basis  = s_q.param[freq_ref_pkg::IDX_AUX_BASIS][0] ? main_f : max_f;
        aux_f  = pick(s_q.param[freq_ref_pkg::IDX_AUX_SRC], basis,
                      s_q.param[freq_ref_pkg::IDX_KEYPAD]);
        case (s_q.param[freq_ref_pkg::IDX_COMBINE][2:0])
            freq_ref_pkg::COMB_MAIN: begin
                combined = main_f;
            end
            freq_ref_pkg::COMB_AUX: begin
                combined = aux_f;
            end
            freq_ref_pkg::COMB_SUM: begin
                sum      = {1'b0, main_f} + {1'b0, aux_f};
                combined = sum[16] ? 16'hFFFF : sum[15:0];
            end
            freq_ref_pkg::COMB_DIFF: begin
                combined = (main_f > aux_f) ? 16'(main_f - aux_f) : 16'h0000;
            end
            freq_ref_pkg::COMB_LARGER: begin
                combined = larger(main_f, aux_f);
            end
            default: begin
                combined = (main_f < aux_f) ? main_f : aux_f;
            end
        endcase
        clamped = combined;
        if (clamped > s_q.param[freq_ref_pkg::IDX_UPPER]) begin
            clamped = s_q.param[freq_ref_pkg::IDX_UPPER];
        end
        if (clamped < s_q.param[freq_ref_pkg::IDX_LOWER]) begin
            clamped = s_q.param[freq_ref_pkg::IDX_LOWER];
        end
        s_d.reference.frequency = clamped;

        // Ramp group, direction and mode outputs
        if (ramp_group_select == 2'h0) begin
            s_d.reference.accel_time = s_q.param[freq_ref_pkg::IDX_ACCEL];
            s_d.reference.decel_time = s_q.param[freq_ref_pkg::IDX_DECEL];
        end else begin
            slot = {ramp_group_select - 2'h1, 1'b0};
            s_d.reference.accel_time = s_q.ramp_time[slot];
            s_d.reference.decel_time = s_q.ramp_time[slot + 3'h1];
        end
        dir = s_q.param[freq_ref_pkg::IDX_DIRECTION][1:0];
        case (dir)
            freq_ref_pkg::DIR_REVERSE: begin
                s_d.reference.reverse = ~reverse_command;
            end
            freq_ref_pkg::DIR_NO_REVERSE: begin
                s_d.reference.reverse = 1'b0;
            end
            default: begin
                s_d.reference.reverse = reverse_command;
            end
        endcase
        s_d.reference.control_mode = s_q.param[freq_ref_pkg::IDX_CONTROL][1:0];
        s_d.reference.run_permit   = autotune_done || (s_q.param[freq_ref_pkg::IDX_CONTROL][1:0]
                                     == freq_ref_pkg::MODE_SPACE_VECTOR_VF);
        s_d.reference.run_source   = s_q.param[freq_ref_pkg::IDX_RUN_SOURCE][1:0];
        s_d.reference.comm_channel = s_q.param[freq_ref_pkg::IDX_COMM][2:0];

        // Parameter access, keypad and serial share one path
        if (request.valid) begin
            src     = request.serial;
            allowed = (s_q.lock[src] == freq_ref_pkg::LOCK_OPEN)
                      || (s_q.password == 16'h0000);
            case (request.group)
                freq_ref_pkg::GROUP_BASIC: begin
                    mapped   = request.index < 7'(freq_ref_pkg::PARAM_COUNT);
                    current  = s_q.param[request.index[3:0]];
                    writable = !(running && freq_ref_pkg::STOP_ONLY_MASK[request.index[3:0]]);
                end
                freq_ref_pkg::GROUP_RAMP: begin
                    mapped   = request.index < 7'(freq_ref_pkg::RAMP_COUNT);
                    current  = s_q.ramp_time[request.index[2:0]];
                    writable = 1'b1;
                end
                freq_ref_pkg::GROUP_PASSWORD: begin
                    mapped   = request.index <= freq_ref_pkg::IDX_LIVE_REF;
                    current  = (request.index == freq_ref_pkg::IDX_LIVE_REF) ?
                               s_q.reference.frequency : (allowed ? s_q.password : 16'h0000);
                    writable = request.index == freq_ref_pkg::IDX_USER_PW;
                end
                freq_ref_pkg::GROUP_FACTORY: begin
                    mapped   = (request.index == freq_ref_pkg::IDX_FACTORY) && s_q.factory_open[src];
                    current  = s_q.factory_trim;
                    writable = 1'b1;
                end
                default: begin
                    mapped = 1'b0;
                end
            endcase
            value = request.data;
            if (request.op == freq_ref_pkg::OP_DIGIT) begin
                value = current;
                value[{request.data[5:4], 2'h0} +: 4] = request.data[3:0];
            end
            s_d.response.done  = 1'b1;
            s_d.response.rdata = 16'h0000;
            case (request.op)
                freq_ref_pkg::OP_READ: begin
                    s_d.response.error = !mapped;
                    s_d.response.rdata = mapped ? current : 16'h0000;
                end
                freq_ref_pkg::OP_WRITE, freq_ref_pkg::OP_DIGIT: begin
                    if (!(allowed && mapped && writable)) begin
                        s_d.response.error = 1'b1;
                    end else if (request.group == freq_ref_pkg::GROUP_BASIC) begin
                        if (basic_ok(request.index[3:0], value, s_q)) begin
                            s_d.param[request.index[3:0]] = value;
                        end else begin
                            s_d.response.error = 1'b1;
                        end
                    end else if (request.group == freq_ref_pkg::GROUP_RAMP) begin
                        if (value <= freq_ref_pkg::RAMP_CEILING) begin
                            s_d.ramp_time[request.index[2:0]] = value;
                        end else begin
                            s_d.response.error = 1'b1;
                        end
                    end else if (request.group == freq_ref_pkg::GROUP_PASSWORD) begin
                        s_d.password = value;
                    end else begin
                        s_d.factory_trim = value;
                    end
                end
                freq_ref_pkg::OP_ENTER: begin
                    s_d.lock[src] = (s_q.password == 16'h0000) ?
                                    freq_ref_pkg::LOCK_OPEN : freq_ref_pkg::LOCK_VERIFY;
                end
                freq_ref_pkg::OP_PASSWORD: begin
                    if ((s_q.lock[src] == freq_ref_pkg::LOCK_VERIFY)
                            && (request.data == s_q.password)) begin
                        s_d.lock[src] = freq_ref_pkg::LOCK_OPEN;
                    end else begin
                        s_d.response.error = 1'b1;
                    end
                end
                freq_ref_pkg::OP_FACTORY: begin
                    if (allowed && (request.data == freq_ref_pkg::FACTORY_PASSWORD)) begin
                        s_d.factory_open[src] = 1'b1;
                    end else begin
                        s_d.response.error = 1'b1;
                    end
                end
                freq_ref_pkg::OP_EXIT: begin
                    s_d.lock[src]         = freq_ref_pkg::LOCK_IDLE;
                    s_d.factory_open[src] = 1'b0;
                end
                freq_ref_pkg::OP_RESTORE: begin
                    if (allowed && !running) begin
                        s_d.param = freq_ref_pkg::PARAM_DEFAULT;
                        for (int i = 0; i < freq_ref_pkg::RAMP_COUNT; i++) begin
                            s_d.ramp_time[i] = freq_ref_pkg::RAMP_DEFAULT;
                        end
                    end else begin
                        s_d.response.error = 1'b1;
                    end
                end
                default: begin
                    s_d.response.error = 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_q              <= '0;
            s_q.param        <= freq_ref_pkg::PARAM_DEFAULT;
            s_q.ramp_time    <= {freq_ref_pkg::RAMP_COUNT{freq_ref_pkg::RAMP_DEFAULT}};
            s_q.password     <= freq_ref_pkg::PASSWORD_RESET;
            s_q.factory_trim <= freq_ref_pkg::FACTORY_TRIM_RESET;
            s_q.lock         <= {freq_ref_pkg::LOCK_IDLE, freq_ref_pkg::LOCK_IDLE};
            s_q.reference.accel_time <= freq_ref_pkg::RAMP_DEFAULT;
            s_q.reference.decel_time <= freq_ref_pkg::RAMP_DEFAULT;
        end else if (enable) begin
            s_q <= s_d;
        end
    end

    assign response  = s_q.response;
    assign reference = s_q.reference;

endmodule : frequency_reference_param_bank

/* hdl/freq_ref_pkg.sv */
//
// Behaviour
// - Always-modifiable parameters accept writes while stopped and while running.
// - Stop-only parameters refuse writes while the drive runs.
// - Measured parameters are read-only; writes leave them unchanged.
// - Hex parameters edit one digit at a time, each digit 0 to F.
// - Restore defaults reloads settable parameters, never measured or recorded values.
// - Nonzero user password: edit entry goes to verification; factory needs factory password.
// - Once unlocked, user password may change anytime; zero disables protection.
// - Serial link writes obey the same password protection as keypad edits.
// - Control mode: 0,1 sensorless vector, 2 space vector V/F, 3 closed loop; reset 2.
// - Run command source: 0 keypad, 1 terminals, 2 communication; reset 0.
// - Comm channel 0 to 5; codes 1 to 5 need the matching card fitted.
// - Above upper limit runs at upper; upper held between lower and maximum.
// - Below lower limit runs at lower; lower ranges zero to upper limit.
// - Maximum frequency from max(upper, 10.00) to 630.00 Hz; scales setting and ramps.
// - Main and aux source codes 0 to 14; 15 reserved, aux reset value.
// - Aux scaling basis: 0 maximum frequency, 1 main frequency command.
// - Combiner codes 0 to 5: main, aux, sum, difference, larger, smaller.
// - Keypad source uses stored keypad frequency, 0 to maximum, reset 50.00 Hz.
// - Accel and decel times span zero to maximum frequency, 0.0 to 3600.0 s.
// - Four ramp-time groups chosen by digital inputs; group one when none selected.
// - Direction: 0 default, 1 reverse, 2 reverse prohibited; reset 0.
// - Vector modes need finished motor autotuning before running.
package freq_ref_pkg;

    // ****************************************
    // Parameter map
    // ****************************************
    localparam int          PARAM_COUNT     = 14;
    localparam int          RAMP_COUNT      = 6;
    localparam logic [6:0]  GROUP_BASIC     = 7'h00;
    localparam logic [6:0]  GROUP_PASSWORD  = 7'h07;
    localparam logic [6:0]  GROUP_RAMP      = 7'h08;
    localparam logic [6:0]  GROUP_FACTORY   = 7'h63;
    localparam logic [3:0]  IDX_CONTROL     = 4'h0;
    localparam logic [3:0]  IDX_RUN_SOURCE  = 4'h1;
    localparam logic [3:0]  IDX_COMM        = 4'h2;
    localparam logic [3:0]  IDX_MAX_FREQ    = 4'h3;
    localparam logic [3:0]  IDX_UPPER       = 4'h4;
    localparam logic [3:0]  IDX_LOWER       = 4'h5;
    localparam logic [3:0]  IDX_MAIN_SRC    = 4'h6;
    localparam logic [3:0]  IDX_AUX_SRC     = 4'h7;
    localparam logic [3:0]  IDX_AUX_BASIS   = 4'h8;
    localparam logic [3:0]  IDX_COMBINE     = 4'h9;
    localparam logic [3:0]  IDX_KEYPAD      = 4'hA;
    localparam logic [3:0]  IDX_ACCEL       = 4'hB;
    localparam logic [3:0]  IDX_DECEL       = 4'hC;
    localparam logic [3:0]  IDX_DIRECTION   = 4'hD;
    localparam logic [6:0]  IDX_USER_PW     = 7'h00;
    localparam logic [6:0]  IDX_LIVE_REF    = 7'h01;
    localparam logic [6:0]  IDX_FACTORY     = 7'h00;

    // ****************************************
    // Defaults, attributes and limits
    // ****************************************
    localparam logic [15:0] RAMP_DEFAULT    = 16'h0064;
    localparam logic [PARAM_COUNT-1:0][15:0] PARAM_DEFAULT = {
        16'h0000, RAMP_DEFAULT, RAMP_DEFAULT, 16'h1388, 16'h0000, 16'h0000, 16'h000F,
        16'h0000, 16'h0000, 16'h1388, 16'h1388, 16'h0000, 16'h0000, 16'h0002};
    localparam logic [PARAM_COUNT-1:0] STOP_ONLY_MASK = 14'h0107;
    localparam logic [15:0] FREQ_CEILING    = 16'hF618;
    localparam logic [15:0] MAX_FREQ_FLOOR  = 16'h03E8;
    localparam logic [15:0] RAMP_CEILING    = 16'h8CA0;
    localparam logic [15:0] CODE_MAX_MODE   = 16'h0003;
    localparam logic [15:0] CODE_MAX_RUN    = 16'h0002;
    localparam logic [15:0] CODE_MAX_COMM   = 16'h0005;
    localparam logic [15:0] CODE_MAX_MAIN   = 16'h000E;
    localparam logic [15:0] CODE_MAX_AUX    = 16'h000F;
    localparam logic [15:0] CODE_MAX_BASIS  = 16'h0001;
    localparam logic [15:0] CODE_MAX_COMB   = 16'h0005;
    localparam logic [15:0] CODE_MAX_DIR    = 16'h0002;
    localparam logic [15:0] FACTORY_TRIM_RESET = 16'h0000;
    localparam logic [15:0] PASSWORD_RESET  = 16'h0000;
    // Arbitrary value
    localparam logic [15:0] FACTORY_PASSWORD = 16'h5A3C;

    // ****************************************
    // Encodings
    // ****************************************
    localparam logic [1:0]  MODE_SPACE_VECTOR_VF = 2'h2;
    localparam logic [3:0]  SRC_KEYPAD      = 4'h0;
    localparam logic [3:0]  SRC_RESERVED    = 4'hF;
    localparam logic [2:0]  COMB_MAIN       = 3'h0;
    localparam logic [2:0]  COMB_AUX        = 3'h1;
    localparam logic [2:0]  COMB_SUM        = 3'h2;
    localparam logic [2:0]  COMB_DIFF       = 3'h3;
    localparam logic [2:0]  COMB_LARGER     = 3'h4;
    localparam logic [1:0]  DIR_REVERSE     = 2'h1;
    localparam logic [1:0]  DIR_NO_REVERSE  = 2'h2;

    typedef enum logic [2:0] {
        OP_READ = 3'h0, OP_WRITE = 3'h1, OP_DIGIT = 3'h2, OP_ENTER = 3'h3,
        OP_PASSWORD = 3'h4, OP_FACTORY = 3'h5, OP_EXIT = 3'h6, OP_RESTORE = 3'h7
    } op_type;

    typedef enum logic [2:0] {
        LOCK_IDLE = 3'b001, LOCK_VERIFY = 3'b010, LOCK_OPEN = 3'b100
    } lock_state_type;

    typedef struct packed {
        logic        valid;
        logic        serial;
        op_type      op;
        logic [6:0]  group;
        logic [6:0]  index;
        logic [15:0] data;
    } request_type;

    typedef struct packed {
        logic        done;
        logic        error;
        logic [15:0] rdata;
    } response_type;

    typedef struct packed {
        logic [15:0] frequency;
        logic [15:0] accel_time;
        logic [15:0] decel_time;
        logic        reverse;
        logic        run_permit;
        logic [1:0]  control_mode;
        logic [1:0]  run_source;
        logic [2:0]  comm_channel;
    } reference_type;

    typedef struct packed {
        logic [PARAM_COUNT-1:0][15:0] param;
        logic [RAMP_COUNT-1:0][15:0]  ramp_time;
        logic [15:0]                  password;
        logic [15:0]                  factory_trim;
        lock_state_type [1:0]         lock;
        logic [1:0]                   factory_open;
        response_type                 response;
        reference_type                reference;
    } state_type;

endpackage : freq_ref_pkg

/* tb/param_master_model.sv */
`timescale 1ns/100ps
module param_master_model (
    input  wire logic                  clock,
    input  freq_ref_pkg::response_type response,
    output freq_ref_pkg::request_type  request
);
    // ****
    // Keypad or serial master
    // ****
    initial request = '0;
    task automatic access(input logic s, input freq_ref_pkg::op_type o, input logic [6:0] g,
        input logic [6:0] i, input logic [15:0] d, output logic e, output logic [15:0] r);
        @(negedge clock);
        request = {1'b1, s, o, g, i, d};
        @(negedge clock);
        request = {1'b0, ~request[33:0]};
        e = response.done ? response.error : 1'bx;
        r = response.rdata;
    endtask : access
endmodule : param_master_model

/* tb/frequency_reference_param_bank_monitor.sv */
`timescale 1ns/100ps
module frequency_reference_param_bank_monitor (
    input wire logic                   clock,
    input wire logic                   reset,
    input wire logic                   enable,
    input wire logic                   running,
    input wire logic                   autotune_done,
    input freq_ref_pkg::request_type   request,
    input freq_ref_pkg::response_type  response,
    input freq_ref_pkg::reference_type reference
);
    // ****
    // Port relations
    // ****
    wire logic wr = enable && request.valid && request.op == freq_ref_pkg::OP_WRITE;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    AST_DONE_FOLLOWS: assert property (enable && request.valid |=> response.done)
        else $error("no answer after request");
    AST_DONE_CAUSE: assert property (response.done |-> $past(enable && request.valid))
        else $error("answer without request");
    AST_ERROR_QUAL: assert property (response.error |-> response.done)
        else $error("error outside answer");
    AST_RDATA_IDLE: assert property (!response.done |-> response.rdata == 16'h0000)
        else $error("read data outside answer");
    AST_STOP_ONLY: assert property (wr && running && request.group == 7'h00
        && request.index == 7'h00 |=> response.error) else $error("stop-only write taken");
    AST_MEASURED: assert property (wr && request.group == 7'h07
        && request.index == 7'h01 |=> response.error) else $error("measured write taken");
    AST_PERMIT: assert property (reference.run_permit && reference.control_mode != 2'h2
        |-> $past(autotune_done)) else $error("vector mode without autotuning");
    AST_FREQ_CEIL: assert property (reference.frequency <= 16'hF618)
        else $error("frequency above ceiling");
    AST_CHANNEL: assert property (reference.comm_channel <= 3'h5)
        else $error("channel code out of range");
    cover property (wr && running);
    cover property (reference.run_permit && reference.control_mode == 2'h0);
    cover property (response.error);
endmodule : frequency_reference_param_bank_monitor
bind frequency_reference_param_bank frequency_reference_param_bank_monitor mon (
    .clock(clock), .reset(reset), .enable(enable), .running(running),
    .autotune_done(autotune_done), .request(request), .response(response),
    .reference(reference));

/* tb/tb_frequency_reference_param_bank.sv */
`timescale 1ns/100ps
module tb_frequency_reference_param_bank;
    // ****
    // Bench
    // ****
    localparam freq_ref_pkg::op_type WR = freq_ref_pkg::OP_WRITE;
    logic clock = 0, reset = 1, running = 0, autotune_done = 0, e;
    logic [15:0] r;
    logic [1:0] grp = 2'h0;
    logic [14:0][15:0] src;
    freq_ref_pkg::request_type req;
    freq_ref_pkg::response_type rsp;
    freq_ref_pkg::reference_type rf;
    int n_errors = 0, checked = 0;
    always #20 clock = ~clock;
    frequency_reference_param_bank dut (.clock(clock), .reset(reset), .enable(1'b1),
        .running(running), .autotune_done(autotune_done), .card_fitted(5'h00),
        .ramp_group_select(grp), .reverse_command(1'b0), .source_level(src),
        .request(req), .response(rsp), .reference(rf));
    param_master_model master (.clock(clock), .response(rsp), .request(req));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic acc(input logic s, input freq_ref_pkg::op_type o, input logic [6:0] g,
        input logic [6:0] i, input logic [15:0] d, input logic ee);
        master.access(s, o, g, i, d, e, r);
        check({15'h0, e}, {15'h0, ee});
    endtask : acc
    task automatic freq(input logic [15:0] x);
        @(negedge clock);
        check(rf.frequency, x);
    endtask : freq
    task automatic t_reset;
        @(negedge clock);
        check(rf.frequency, 16'h1388);
        check({14'h0, rf.control_mode}, 16'h0002);
        check({14'h0, rf.run_source}, 16'h0000);
        for (int i = 0; i < 14; i++) begin
            acc(1'b0, freq_ref_pkg::OP_READ, 7'h00, 7'(i), 16'h0000, 1'b0);
            check(r, freq_ref_pkg::PARAM_DEFAULT[i]);
        end
    endtask : t_reset
    task automatic t_limits;
        acc(1'b0, WR, 7'h00, 7'h04, 16'h0FA0, 1'b0);
        freq(16'h0FA0);
        acc(1'b0, WR, 7'h00, 7'h05, 16'h0BB8, 1'b0);
        acc(1'b0, WR, 7'h00, 7'h0A, 16'h03E8, 1'b0);
        freq(16'h0BB8);
        acc(1'b0, WR, 7'h00, 7'h05, 16'h1388, 1'b1);
        acc(1'b0, WR, 7'h00, 7'h03, 16'h0064, 1'b1);
        acc(1'b0, freq_ref_pkg::OP_RESTORE, 7'h00, 7'h00, 16'h0000, 1'b0);
        freq(16'h1388);
    endtask : t_limits
    task automatic t_combine;
        logic [15:0] cx [6] = '{16'h03E8, 16'h09C4, 16'h0DAC, 16'h0000, 16'h09C4, 16'h03E8};
        acc(1'b0, WR, 7'h00, 7'h0A, 16'h03E8, 1'b0);
        acc(1'b0, WR, 7'h00, 7'h07, 16'h0001, 1'b0);
        for (int k = 0; k < 6; k++) begin
            acc(1'b0, WR, 7'h00, 7'h09, 16'(k), 1'b0);
            freq(cx[k]);
        end
    endtask : t_combine
    task automatic t_running;
        running = 1'b1;
        acc(1'b0, WR, 7'h00, 7'h00, 16'h0000, 1'b1);
        acc(1'b0, WR, 7'h00, 7'h0A, 16'h07D0, 1'b0);
        acc(1'b0, WR, 7'h07, 7'h01, 16'h0000, 1'b1);
        running = 1'b0;
    endtask : t_running
    task automatic t_mode;
        acc(1'b0, WR, 7'h00, 7'h00, 16'h0000, 1'b0);
        @(negedge clock);
        check({15'h0, rf.run_permit}, 16'h0000);
        autotune_done = 1'b1;
        @(negedge clock);
        check({15'h0, rf.run_permit}, 16'h0001);
    endtask : t_mode
    task automatic t_password;
        acc(1'b0, WR, 7'h07, 7'h00, 16'h1234, 1'b0);
        acc(1'b0, WR, 7'h00, 7'h0A, 16'h0100, 1'b1);
        acc(1'b1, WR, 7'h00, 7'h0A, 16'h0100, 1'b1);
        acc(1'b0, freq_ref_pkg::OP_ENTER, 7'h00, 7'h00, 16'h0000, 1'b0);
        acc(1'b0, freq_ref_pkg::OP_PASSWORD, 7'h00, 7'h00, 16'h1234, 1'b0);
        acc(1'b0, WR, 7'h00, 7'h0A, 16'h0100, 1'b0);
        acc(1'b0, WR, 7'h07, 7'h00, 16'h0000, 1'b0);
        acc(1'b1, WR, 7'h00, 7'h0A, 16'h0200, 1'b0);
    endtask : t_password
    task automatic t_more;
        grp = 2'h1;
        acc(1'b0, WR, 7'h08, 7'h00, 16'h0032, 1'b0);
        acc(1'b0, WR, 7'h00, 7'h0D, 16'h0001, 1'b0);
        acc(1'b0, freq_ref_pkg::OP_DIGIT, 7'h00, 7'h0A, 16'h0025, 1'b0);
        freq(16'h0500);
        check(rf.accel_time, 16'h0032);
        check({15'h0, rf.reverse}, 16'h0001);
    endtask : t_more
    task automatic complete_run;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    initial begin
        src = '0;
        src[1] = 16'h8000;
        repeat (10) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        t_reset();
        t_limits();
        t_combine();
        t_running();
        t_mode();
        t_password();
        t_more();
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge clock);
        n_errors++;
        complete_run();
    end
endmodule : tb_frequency_reference_param_bank
